// >>> hdl/pacer_defines.svh
// Purpose: constants for the MAC control interrupt pacer
// Assumes: 100 MHz mclk
// Notes: memory sizes, window and pacing counts, main widths and EOI codes live here
`ifndef PACER_DEFINES_SVH
`define PACER_DEFINES_SVH
`define DESC_MEM_BYTES 8192
`define DESC_BYTES 16
`define DESC_WORDS 2048
`define DESC_ADDR_W 11
`define WINDOW_TICKS 250
`define TICK_W 8
`define PRESCALE_W 12
`define PACE_W 8
`define PACE_DEFAULT 8'h04
`define CHAN_N 8
`define MISC_N 4
`define EOI_THRESH 2'h0
`define EOI_RX 2'h1
`define EOI_TX 2'h2
`define EOI_MISC 2'h3
`endif

// >>> hdl/pacer_pkg.sv
// Purpose: shared types for the pacer block
// Assumes: nothing
// Notes: arbiter grant states
package pacer_pkg;
   typedef enum logic [2:0] {
      ARB_IDLE = 3'b001,
      ARB_CPU = 3'b010,
      ARB_MAC = 3'b100
   } arb_state_e;
endpackage

// >>> hdl/pace_channel.sv
// Purpose: adaptive pacing of one pulse interrupt path
// Assumes: tick is a one-cycle 4 us strobe
// Notes: events arriving while blocked stay pending
`timescale 1ns/1ns
`default_nettype none
`include "pacer_defines.svh"
module pace_channel #(
   parameter int PACE_W = `PACE_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick,
   input wire logic window_end,
   input wire logic event_in,
   input wire logic pace_enable,
   input wire logic [PACE_W-1:0] target,
   output logic pulse
);
   logic pending_r, pending_nxt; // Event waiting for a window
   logic pulse_r, pulse_nxt; // Output pulse
   logic [PACE_W-1:0] count_r, count_nxt; // Interrupts in this 1 ms window
   logic [PACE_W-1:0] reload_r, reload_nxt; // Blocking length in ticks
   logic [PACE_W-1:0] timer_r, timer_nxt; // Pacing timer
   logic blocked;

   assign blocked = pace_enable && (timer_r != '0);
   assign pulse = pulse_r;

   // Next state: pend, fire, count, adapt
   always_comb begin
      pending_nxt = pending_r | event_in;
      pulse_nxt = 1'b0;
      count_nxt = count_r;
      reload_nxt = reload_r;
      timer_nxt = timer_r;
      if (pending_nxt && !blocked) begin
         pulse_nxt = 1'b1;
         pending_nxt = 1'b0;
         count_nxt = (count_r == '1) ? count_r : count_r + 1'b1;
         if (pace_enable) begin
            timer_nxt = reload_r;
         end
      end else if (tick && timer_r != '0) begin
         timer_nxt = timer_r - 1'b1;
      end
      // Window end: more than target lengthens blocking, fewer shortens
      if (window_end) begin
         if (count_nxt > target && reload_r != '1) begin
            reload_nxt = reload_r + 1'b1;
         end else if (count_nxt < target && reload_r != '0) begin
            reload_nxt = reload_r - 1'b1;
         end
         count_nxt = '0;
      end
   end

   // Registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         pending_r <= 1'b0;
         pulse_r <= 1'b0;
         count_r <= '0;
         reload_r <= `PACE_DEFAULT;
         timer_r <= '0;
      end else begin
         pending_r <= pending_nxt;
         pulse_r <= pulse_nxt;
         count_r <= count_nxt;
         reload_r <= reload_nxt;
         timer_r <= timer_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/desc_ram.sv
// Purpose: local descriptor memory, flip-flop storage
// Assumes: one port, one access per cycle
// Notes: read data registered, one cycle latency
`timescale 1ns/1ns
`default_nettype none
`include "pacer_defines.svh"
module desc_ram #(
   parameter int WORDS = `DESC_WORDS,
   parameter int AW = `DESC_ADDR_W
) (
   input wire logic mclk,
   input wire logic en,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   logic [31:0] mem [WORDS]; // 8K bytes, 512 descriptors of 16 bytes
   logic [31:0] rdata_r;
   assign rdata = rdata_r;
   // Write and registered read
   always_ff @(posedge mclk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
      if (en) begin
         rdata_r <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// >>> hdl/mac_control_interrupt_pacer.sv
// Purpose: interrupt combining, pacing, descriptor memory and arbitration
// Assumes: mclk is the peripheral clock; all inputs synchronous
// Notes: system-memory arbitration is round robin between two MAC buses
`timescale 1ns/1ns
`default_nettype none
`include "pacer_defines.svh"
module mac_control_interrupt_pacer #(
   parameter int CHAN_N = `CHAN_N,
   parameter int PRESCALE_W = `PRESCALE_W,
   parameter int WINDOW_TICKS = `WINDOW_TICKS,
   parameter int AW = `DESC_ADDR_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [CHAN_N-1:0] raw_transmit_pending,
   input wire logic [CHAN_N-1:0] raw_receive_pending,
   input wire logic [CHAN_N-1:0] raw_threshold_pending,
   input wire logic statistics_pending,
   input wire logic host_error_pending,
   input wire logic mgmt_link_change_event,
   input wire logic mgmt_access_done_event,
   input wire logic [CHAN_N-1:0] transmit_source_mask,
   input wire logic [CHAN_N-1:0] receive_source_mask,
   input wire logic [CHAN_N-1:0] threshold_source_mask,
   input wire logic [`MISC_N-1:0] misc_source_mask,
   input wire logic [PRESCALE_W-1:0] int_prescale,
   input wire logic pace_transmit_enable,
   input wire logic pace_receive_enable,
   input wire logic [`PACE_W-1:0] transmit_target,
   input wire logic [`PACE_W-1:0] receive_target,
   input wire logic end_of_interrupt_strobe,
   input wire logic [1:0] end_of_interrupt_vector,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [AW-1:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   input wire logic mac_req,
   input wire logic mac_we,
   input wire logic [AW-1:0] mac_addr,
   input wire logic [31:0] mac_wdata,
   input wire logic [1:0] sys_req,
   output logic [CHAN_N-1:0] transmit_masked_status,
   output logic [CHAN_N-1:0] receive_masked_status,
   output logic [CHAN_N-1:0] threshold_masked_status,
   output logic [`MISC_N-1:0] misc_masked_status,
   output logic transmit_pulse,
   output logic receive_pulse,
   output logic threshold_pulse,
   output logic misc_pulse,
   output logic cpu_ack,
   output logic mac_ack,
   output logic [31:0] desc_rdata,
   output logic [1:0] sys_grant
);
   // Masked status registers
   logic [CHAN_N-1:0] tx_stat_r, tx_stat_nxt;
   logic [CHAN_N-1:0] rx_stat_r, rx_stat_nxt;
   logic [CHAN_N-1:0] th_stat_r, th_stat_nxt;
   logic [`MISC_N-1:0] misc_stat_r, misc_stat_nxt;
   // Armed flags: a line fires once, then waits for its end-of-interrupt
   logic [3:0] armed_r, armed_nxt;
   logic th_pulse_r, th_pulse_nxt;
   logic misc_pulse_r, misc_pulse_nxt;
   logic tx_event, rx_event;
   logic tx_pace_pulse, rx_pace_pulse;
   logic tx_pulse_r, rx_pulse_r;
   // Timebase
   logic [PRESCALE_W-1:0] pre_r, pre_nxt;
   logic [`TICK_W-1:0] win_r, win_nxt;
   logic tick_r, tick_nxt;
   logic win_end_r, win_end_nxt;
   // Arbiter
   pacer_pkg::arb_state_e arb_r, arb_nxt;
   logic last_cpu_r, last_cpu_nxt; // Fairness bit for the descriptor port
   logic cpu_ack_r, cpu_ack_nxt;
   logic mac_ack_r, mac_ack_nxt;
   logic [1:0] sys_grant_r, sys_grant_nxt;
   logic sys_last_r, sys_last_nxt;
   logic ram_en, ram_we;
   logic [AW-1:0] ram_addr;
   logic [31:0] ram_wdata;

   // Status capture and immediate lines
   always_comb begin
      tx_stat_nxt = raw_transmit_pending & transmit_source_mask;
      rx_stat_nxt = raw_receive_pending & receive_source_mask;
      th_stat_nxt = raw_threshold_pending & threshold_source_mask;
      misc_stat_nxt = {mgmt_access_done_event, mgmt_link_change_event,
                       host_error_pending, statistics_pending} & misc_source_mask;
      armed_nxt = armed_r;
      th_pulse_nxt = 1'b0;
      misc_pulse_nxt = 1'b0;
      tx_event = 1'b0;
      rx_event = 1'b0;
      // Re-arm on end-of-interrupt; the vector picks the line
      if (end_of_interrupt_strobe) begin
         case (end_of_interrupt_vector)
            `EOI_THRESH: armed_nxt[0] = 1'b1;
            `EOI_RX: armed_nxt[1] = 1'b1;
            `EOI_TX: armed_nxt[2] = 1'b1;
            `EOI_MISC: armed_nxt[3] = 1'b1;
            default: armed_nxt = armed_r;
         endcase
      end
      // Fire on armed line with masked status; fire wins over re-arm
      if (armed_r[0] && th_stat_r != '0) begin
         th_pulse_nxt = 1'b1;
         armed_nxt[0] = 1'b0;
      end
      if (armed_r[1] && rx_stat_r != '0) begin
         rx_event = 1'b1;
         armed_nxt[1] = 1'b0;
      end
      if (armed_r[2] && tx_stat_r != '0) begin
         tx_event = 1'b1;
         armed_nxt[2] = 1'b0;
      end
      if (armed_r[3] && misc_stat_r != '0) begin
         misc_pulse_nxt = 1'b1;
         armed_nxt[3] = 1'b0;
      end
   end

   // Status registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_stat_r <= '0;
         rx_stat_r <= '0;
         th_stat_r <= '0;
         misc_stat_r <= '0;
         armed_r <= 4'hF;
         th_pulse_r <= 1'b0;
         misc_pulse_r <= 1'b0;
         tx_pulse_r <= 1'b0;
         rx_pulse_r <= 1'b0;
      end else begin
         tx_stat_r <= tx_stat_nxt;
         rx_stat_r <= rx_stat_nxt;
         th_stat_r <= th_stat_nxt;
         misc_stat_r <= misc_stat_nxt;
         armed_r <= armed_nxt;
         th_pulse_r <= th_pulse_nxt;
         misc_pulse_r <= misc_pulse_nxt;
         tx_pulse_r <= tx_pace_pulse; // Extra flop keeps the output a pure register
         rx_pulse_r <= rx_pace_pulse;
      end
   end

   // Prescaler and 1 ms window; prescale of zero stalls the tick
   always_comb begin
      pre_nxt = pre_r;
      win_nxt = win_r;
      tick_nxt = 1'b0;
      win_end_nxt = 1'b0;
      if (int_prescale == '0) begin
         pre_nxt = '0;
      end else if (pre_r == '0) begin
         pre_nxt = int_prescale - 1'b1;
         tick_nxt = 1'b1;
         if (win_r == '0) begin
            win_nxt = `TICK_W'(WINDOW_TICKS - 1);
            win_end_nxt = 1'b1;
         end else begin
            win_nxt = win_r - 1'b1;
         end
      end else begin
         pre_nxt = pre_r - 1'b1;
      end
   end

   // Timebase registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         pre_r <= '0;
         win_r <= `TICK_W'(WINDOW_TICKS - 1);
         tick_r <= 1'b0;
         win_end_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         win_r <= win_nxt;
         tick_r <= tick_nxt;
         win_end_r <= win_end_nxt;
      end
   end

   // Pacing only on transmit and receive
   pace_channel #(.PACE_W(`PACE_W)) u_tx_pace (
      .mclk(mclk),
      .rst(rst),
      .tick(tick_r),
      .window_end(win_end_r),
      .event_in(tx_event),
      .pace_enable(pace_transmit_enable),
      .target(transmit_target),
      .pulse(tx_pace_pulse)
   );
   pace_channel #(.PACE_W(`PACE_W)) u_rx_pace (
      .mclk(mclk),
      .rst(rst),
      .tick(tick_r),
      .window_end(win_end_r),
      .event_in(rx_event),
      .pace_enable(pace_receive_enable),
      .target(receive_target),
      .pulse(rx_pace_pulse)
   );

   // Descriptor port arbiter: alternate on contention, one cycle grant
   always_comb begin
      arb_nxt = pacer_pkg::ARB_IDLE;
      last_cpu_nxt = last_cpu_r;
      cpu_ack_nxt = 1'b0;
      mac_ack_nxt = 1'b0;
      // A requester still holds req in its ack cycle; granting it then would repeat the access
      if (cpu_req && (!mac_req || !last_cpu_r) && arb_r != pacer_pkg::ARB_CPU && !cpu_ack_r) begin
         arb_nxt = pacer_pkg::ARB_CPU;
      end else if (mac_req && arb_r != pacer_pkg::ARB_MAC && !mac_ack_r) begin
         arb_nxt = pacer_pkg::ARB_MAC;
      end
      case (arb_r)
         pacer_pkg::ARB_IDLE: begin
         end
         pacer_pkg::ARB_CPU: begin
            cpu_ack_nxt = 1'b1;
            last_cpu_nxt = 1'b1;
         end
         pacer_pkg::ARB_MAC: begin
            mac_ack_nxt = 1'b1;
            last_cpu_nxt = 1'b0;
         end
         default: arb_nxt = pacer_pkg::ARB_IDLE;
      endcase
      // System-memory round robin between two MAC buses
      sys_grant_nxt = 2'h0;
      sys_last_nxt = sys_last_r;
      if (sys_req == 2'h3) begin
         sys_grant_nxt = sys_last_r ? 2'h1 : 2'h2;
         sys_last_nxt = ~sys_last_r;
      end else begin
         sys_grant_nxt = sys_req;
      end
   end

   // Memory is driven by whoever holds the grant this cycle
   assign ram_en = (arb_r == pacer_pkg::ARB_CPU) || (arb_r == pacer_pkg::ARB_MAC);
   assign ram_we = (arb_r == pacer_pkg::ARB_CPU) ? cpu_we : mac_we;
   assign ram_addr = (arb_r == pacer_pkg::ARB_CPU) ? cpu_addr : mac_addr;
   assign ram_wdata = (arb_r == pacer_pkg::ARB_CPU) ? cpu_wdata : mac_wdata;

   // Arbiter registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         arb_r <= pacer_pkg::ARB_IDLE;
         last_cpu_r <= 1'b0;
         cpu_ack_r <= 1'b0;
         mac_ack_r <= 1'b0;
         sys_grant_r <= 2'h0;
         sys_last_r <= 1'b0;
      end else begin
         arb_r <= arb_nxt;
         last_cpu_r <= last_cpu_nxt;
         cpu_ack_r <= cpu_ack_nxt;
         mac_ack_r <= mac_ack_nxt;
         sys_grant_r <= sys_grant_nxt;
         sys_last_r <= sys_last_nxt;
      end
   end

   desc_ram #(.WORDS(`DESC_WORDS), .AW(AW)) u_desc_ram (
      .mclk(mclk),
      .en(ram_en),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(desc_rdata)
   );

   // Four interrupt lines, all registered
   assign transmit_pulse = tx_pulse_r;
   assign receive_pulse = rx_pulse_r;
   assign threshold_pulse = th_pulse_r;
   assign misc_pulse = misc_pulse_r;
   assign transmit_masked_status = tx_stat_r;
   assign receive_masked_status = rx_stat_r;
   assign threshold_masked_status = th_stat_r;
   assign misc_masked_status = misc_stat_r;
   assign cpu_ack = cpu_ack_r;
   assign mac_ack = mac_ack_r;
   assign sys_grant = sys_grant_r;
endmodule
`default_nettype wire

// >>> verification/pacer_checker.sv
// Purpose: port-level checks of the interrupt pacer
// Assumes: mclk clock, rst synchronous active high
// Notes: status checks skip the first edge after reset release
`timescale 1ns/1ns
`default_nettype none
module pacer_checker #(
   parameter int CHAN_N = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [CHAN_N-1:0] raw_transmit_pending,
   input wire logic [CHAN_N-1:0] raw_threshold_pending,
   input wire logic statistics_pending,
   input wire logic host_error_pending,
   input wire logic mgmt_link_change_event,
   input wire logic mgmt_access_done_event,
   input wire logic [CHAN_N-1:0] transmit_source_mask,
   input wire logic [CHAN_N-1:0] threshold_source_mask,
   input wire logic [3:0] misc_source_mask,
   input wire logic [CHAN_N-1:0] transmit_masked_status,
   input wire logic [CHAN_N-1:0] threshold_masked_status,
   input wire logic [3:0] misc_masked_status,
   input wire logic transmit_pulse,
   input wire logic receive_pulse,
   input wire logic threshold_pulse,
   input wire logic misc_pulse,
   input wire logic cpu_req,
   input wire logic cpu_ack,
   input wire logic [1:0] sys_req,
   input wire logic [1:0] sys_grant
);
   // All four lines side by side, and the misc sources in mask bit order
   wire logic [3:0] pv = {misc_pulse, threshold_pulse, receive_pulse, transmit_pulse};
   wire logic [3:0] mraw = {mgmt_access_done_event, mgmt_link_change_event, host_error_pending, statistics_pending};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Status is raw and mask, one cycle late; the edge after reset is skipped
   a_tx_status: assert property (!$past(rst) |->
      transmit_masked_status == $past(raw_transmit_pending & transmit_source_mask)) else $error("tx status wrong");
   a_thr_status: assert property (!$past(rst) |->
      threshold_masked_status == $past(raw_threshold_pending & threshold_source_mask)) else $error("thr status wrong");
   a_misc_status: assert property (!$past(rst) |->
      misc_masked_status == $past(mraw & misc_source_mask)) else $error("misc status wrong");
   // Unpaced lines fire only from a nonzero masked status
   a_thr_cause: assert property (threshold_pulse |-> $past(threshold_masked_status) != 8'h00)
      else $error("thr pulse without cause");
   a_misc_cause: assert property (misc_pulse |-> $past(misc_masked_status) != 4'h0)
      else $error("misc pulse without cause");
   a_pulse_width: assert property (pv != 4'h0 |=> (pv & $past(pv)) == 4'h0)
      else $error("pulse longer than one cycle");
   a_grant_follow: assert property (sys_req != 2'h0 |=> $onehot(sys_grant) && (sys_grant & $past(sys_req)) != 2'h0)
      else $error("system grant wrong");
   a_ack_bound: assert property ($rose(cpu_req) |-> ##[2:8] cpu_ack)
      else $error("cpu ack late");
   c_tx: cover property (transmit_pulse);
   c_ack: cover property (cpu_ack);
   c_alt: cover property (sys_grant == 2'h2);
endmodule
bind mac_control_interrupt_pacer pacer_checker #(.CHAN_N(CHAN_N)) i_checker (.*);
`default_nettype wire

// >>> verification/host_irq_model.sv
// Purpose: interrupt controller and driver model that ends each interrupt
// Assumes: pulses ordered {misc, thr, rx, tx}
// Notes: serves one line at a time after a chosen delay
`timescale 1ns/1ns
`default_nettype none
module host_irq_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [3:0] pulses,
   input wire logic [3:0] delay,
   output logic eoi_strobe,
   output logic [1:0] eoi_vector
);
   logic [3:0] pend;
   logic [3:0] cnt;
   // Remember every pulse, then after the delay end the lowest pending one
   always @(posedge mclk) begin
      eoi_strobe <= 1'b0;
      eoi_vector <= ~eoi_vector; // Released vector never shows a stable old code
      if (rst) begin
         pend <= 4'h0;
         cnt <= 4'h0;
      end else if ((pend != 4'h0) && (cnt >= delay)) begin
         cnt <= 4'h0;
         eoi_strobe <= 1'b1;
         for (int i = 3; i >= 0; i--) begin
            if (pend[i]) begin
               eoi_vector <= (i == 0) ? 2'h2 : (i == 1) ? 2'h1 : (i == 2) ? 2'h0 : 2'h3;
               pend <= (pend & ~(4'h1 << i)) | pulses;
            end
         end
      end else begin
         pend <= pend | pulses;
         cnt <= (pend != 4'h0) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_mac_control_interrupt_pacer.sv
// Purpose: self-checking bench of the interrupt pacer
// Assumes: window shortened to 4 ticks, tick every 100 cycles
// Notes: random masks and sources from a fixed lfsr seed
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module tb_mac_control_interrupt_pacer;
   logic mclk, rst, statistics_pending, host_error_pending, mgmt_link_change_event, mgmt_access_done_event;
   logic [7:0] raw_transmit_pending, raw_receive_pending, raw_threshold_pending, transmit_target, receive_target;
   logic [7:0] transmit_source_mask, receive_source_mask, threshold_source_mask;
   logic [3:0] misc_source_mask, eoi_delay;
   logic [11:0] int_prescale;
   logic pace_transmit_enable, pace_receive_enable, cpu_req, cpu_we, mac_req, mac_we;
   logic [10:0] cpu_addr, mac_addr;
   logic [31:0] cpu_wdata, mac_wdata, q0, q1;
   logic [1:0] sys_req, g_seen;
   logic [15:0] seed;
   wire logic end_of_interrupt_strobe, transmit_pulse, receive_pulse, threshold_pulse, misc_pulse, cpu_ack, mac_ack;
   wire logic [1:0] end_of_interrupt_vector, sys_grant;
   wire logic [7:0] transmit_masked_status, receive_masked_status, threshold_masked_status;
   wire logic [3:0] misc_masked_status;
   wire logic [31:0] desc_rdata;
   wire logic [3:0] pv = {misc_pulse, threshold_pulse, receive_pulse, transmit_pulse};
   int failures = 0, cmp_count = 0, cyc = 0, rx_cnt = 0, t0, n;
   mac_control_interrupt_pacer #(.WINDOW_TICKS(4)) i_dut (.*);
   host_irq_model i_host (.mclk(mclk), .rst(rst), .pulses(pv), .delay(eoi_delay),
      .eoi_strobe(end_of_interrupt_strobe), .eoi_vector(end_of_interrupt_vector));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Cycle count, rx pulse count and the hang limit
   always @(posedge mclk) begin
      cyc++;
      if (receive_pulse === 1'b1) rx_cnt++;
      if (cyc == 8000) begin
         failures++;
         report_and_stop;
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] masked(input logic [7:0] r, input logic [7:0] m);
      return r & m;
   endfunction
   task automatic do_reset;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
   endtask
   // Counts cycles from the driving edge to the pulse; a pulse is one cycle wide
   task automatic pulse_lat(input int i, input int exp, input string nm);
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (pv[i] !== 1'b1 && n < 60);
      `CHECK(nm, exp, n)
   endtask
   // One descriptor access; request and qualifiers held until the ack edge
   task automatic mem_rw(input bit m, input logic we, input logic [10:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int k;
      k = 0;
      @(posedge mclk);
      if (m) {mac_req, mac_we, mac_addr, mac_wdata} <= {1'b1, we, a, d};
      else {cpu_req, cpu_we, cpu_addr, cpu_wdata} <= {1'b1, we, a, d};
      do begin
         @(posedge mclk);
         k++;
      end while ((m ? mac_ack : cpu_ack) !== 1'b1 && k < 20);
      q = desc_rdata;
      if (m) {mac_req, mac_addr, mac_wdata} <= {1'b0, ~a, ~d};
      else {cpu_req, cpu_addr, cpu_wdata} <= {1'b0, ~a, ~d};
      `CHECK("ack in time", 1'b1, k < 20)
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {rst, statistics_pending, host_error_pending, mgmt_link_change_event, mgmt_access_done_event} = 5'h10;
      {raw_transmit_pending, raw_receive_pending, raw_threshold_pending, transmit_target, receive_target} = '0;
      {transmit_source_mask, receive_source_mask, threshold_source_mask, misc_source_mask} = '0;
      {pace_transmit_enable, pace_receive_enable, cpu_req, cpu_we, mac_req, mac_we, sys_req} = '0;
      {cpu_addr, mac_addr, cpu_wdata, mac_wdata} = '0;
      int_prescale = 12'h064;
      eoi_delay = 4'h3;
      seed = 16'h9152;
      do_reset;
      @(posedge mclk);
      #1;
      `CHECK("idle after reset", 32'h0, {transmit_masked_status, receive_masked_status, threshold_masked_status, misc_masked_status, pv})
      // Random sources and masks; status is raw and mask one cycle later
      repeat (40) begin
         @(posedge mclk);
         seed = lfsr(seed);
         {raw_transmit_pending, transmit_source_mask} <= seed;
         seed = lfsr(seed);
         {raw_receive_pending, receive_source_mask} <= seed;
         seed = lfsr(seed);
         {raw_threshold_pending, threshold_source_mask} <= seed;
         seed = lfsr(seed);
         {mgmt_access_done_event, mgmt_link_change_event, host_error_pending, statistics_pending} <= seed[3:0];
         {misc_source_mask, sys_req, eoi_delay, transmit_target[1:0]} <= seed[15:4];
         @(posedge mclk);
         #1;
         `CHECK("tx status", masked(raw_transmit_pending, transmit_source_mask), transmit_masked_status)
         `CHECK("rx status", masked(raw_receive_pending, receive_source_mask), receive_masked_status)
         `CHECK("thr status", masked(raw_threshold_pending, threshold_source_mask), threshold_masked_status)
         `CHECK("misc status", masked({mgmt_access_done_event, mgmt_link_change_event, host_error_pending,
            statistics_pending}, misc_source_mask), {4'h0, misc_masked_status})
      end
      @(posedge mclk);
      {raw_transmit_pending, raw_receive_pending, raw_threshold_pending, sys_req} <= '0;
      {mgmt_access_done_event, mgmt_link_change_event, host_error_pending, statistics_pending} <= 4'h0;
      {receive_source_mask, threshold_source_mask} <= 16'h0010;
      eoi_delay <= 4'h3; // Short fixed service time, so every line is re-armed before the latency checks
      repeat (40) @(posedge mclk);
      raw_threshold_pending <= 8'h10;
      pulse_lat(2, 2, "thr latency");
      raw_threshold_pending <= 8'h00;
      // Each misc source alone through its own mask bit
      for (int i = 0; i < 4; i++) begin
         repeat (20) @(posedge mclk);
         misc_source_mask <= 4'h1 << i;
         {mgmt_access_done_event, mgmt_link_change_event, host_error_pending, statistics_pending} <= 4'h1 << i;
         pulse_lat(3, 2, "misc latency");
         @(posedge mclk);
         {mgmt_access_done_event, mgmt_link_change_event, host_error_pending, statistics_pending} <= 4'h0;
      end
      // Masked receive sources stay silent, then fire once enabled
      raw_receive_pending <= 8'hFF;
      t0 = rx_cnt;
      repeat (20) @(posedge mclk);
      `CHECK("rx masked off", t0, rx_cnt)
      receive_source_mask <= 8'h80;
      pulse_lat(1, 3, "rx latency");
      raw_receive_pending <= 8'h00;
      // Contending writes at both ends of memory, then crossed reads
      fork
         mem_rw(1'b0, 1'b1, 11'h000, 32'hA5C3_0F01, q0);
         mem_rw(1'b1, 1'b1, 11'h7FF, 32'h5A3C_F0FE, q1);
      join
      fork
         mem_rw(1'b0, 1'b0, 11'h7FF, 32'h0, q0);
         mem_rw(1'b1, 1'b0, 11'h000, 32'h0, q1);
      join
      `CHECK("cpu read top word", 32'h5A3C_F0FE, q0)
      `CHECK("mac read word 0", 32'hA5C3_0F01, q1)
      sys_req <= 2'h3;
      g_seen = 2'h0;
      repeat (6) @(posedge mclk) g_seen |= sys_grant;
      `CHECK("both buses granted", 2'h3, g_seen)
      sys_req <= 2'h0;
      // Paced transmit: second event pends until the 4-tick block has run out
      pace_transmit_enable <= 1'b1;
      transmit_source_mask <= 8'h01;
      do_reset;
      raw_transmit_pending <= 8'h01;
      pulse_lat(0, 3, "tx latency");
      t0 = cyc;
      raw_transmit_pending <= 8'h00;
      repeat (20) @(posedge mclk);
      raw_transmit_pending <= 8'h01;
      repeat (10) @(posedge mclk);
      raw_transmit_pending <= 8'h00;
      pulse_lat(0, 60, "tx held while blocked");
      n = 0;
      while (transmit_pulse !== 1'b1 && n < 700) begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHECK("tx paced gap", 1'b1, (cyc - t0 >= 300) && (cyc - t0 <= 520))
      report_and_stop;
   end
endmodule
`default_nettype wire
